// ---- dv/carl_ctrl_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Control-side stand-in driving stage strobes
// ----------------------------------------
module carl_ctrl_model (
	input  wire logic          pclk,
	output logic               parallel_select,
	output logic               serial_shift_feed,
	output logic               stage1_load_strobe,
	output logic               stage1_clock,
	output logic [11:0]        in_word,
	output carl_pkg::carl_sel_t sel,
	output logic               stage2_clock,
	output logic               stage2_load_strobe,
	output logic               stage3_clock
);
	import carl_pkg::*;

	initial begin
		parallel_select = 1'b1;
		serial_shift_feed = 1'b0;
		stage1_load_strobe = 1'b0;
		stage1_clock = 1'b0;
		in_word = 12'h000;
		sel = 3'h0;
		stage2_clock = 1'b0;
		stage2_load_strobe = 1'b0;
		stage3_clock = 1'b0;
	end

	task stage1(input logic [11:0] w, input logic stb, input logic c1);
		@(posedge pclk);
		parallel_select <= 1'b1;
		in_word <= w;
		stage1_load_strobe <= stb;
		stage1_clock <= c1;
		@(posedge pclk);
		stage1_load_strobe <= 1'b0;
		stage1_clock <= 1'b0;
		// Released word inverted so a stale value cannot pass for a load
		in_word <= ~w;
	endtask : stage1

	task shift_in(input logic [11:0] w);
		for (int i = 11; i >= 0; i--) begin
			@(posedge pclk);
			parallel_select <= 1'b0;
			stage1_clock <= 1'b1;
			serial_shift_feed <= w[i];
		end
		@(posedge pclk);
		parallel_select <= 1'b1;
		stage1_clock <= 1'b0;
		serial_shift_feed <= ~w[0];
	endtask : shift_in

	task set_sel(input carl_sel_t s);
		@(posedge pclk);
		sel <= s;
	endtask : set_sel

	task stage2(input carl_sel_t s, input logic stb);
		@(posedge pclk);
		sel <= s;
		stage2_clock <= 1'b1;
		stage2_load_strobe <= stb;
		@(posedge pclk);
		stage2_clock <= 1'b0;
		stage2_load_strobe <= 1'b0;
	endtask : stage2

	task stage3;
		@(posedge pclk);
		stage3_clock <= 1'b1;
		@(posedge pclk);
		stage3_clock <= 1'b0;
	endtask : stage3
endmodule : carl_ctrl_model

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	import carl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ce;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        parallel_select, serial_shift_feed, serial_shift_exit, stage1_load_strobe;
	logic        stage1_clock, stage2_clock, stage2_load_strobe, stage3_clock, next_even;
	logic [11:0] in_word, prev_value_bus, true_odd_q, true_even_q, displacement_q;
	logic [11:0] stage3_odd_q, stage3_even_q, odd_e, even_e, aux_e;
	carl_sel_t   sel;
	carl_flags_t flags_q;
	int          failures, samples_checked, cycles;

	carl_adder i_carl_adder (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.parallel_select(parallel_select), .serial_shift_feed(serial_shift_feed),
		.serial_shift_exit(serial_shift_exit), .stage1_load_strobe(stage1_load_strobe),
		.stage1_clock(stage1_clock), .in_word(in_word), .sel(sel),
		.stage2_clock(stage2_clock), .stage2_load_strobe(stage2_load_strobe),
		.stage3_clock(stage3_clock), .prev_value_bus(prev_value_bus),
		.true_odd_q(true_odd_q), .true_even_q(true_even_q),
		.displacement_q(displacement_q), .flags_q(flags_q),
		.stage3_odd_q(stage3_odd_q), .stage3_even_q(stage3_even_q));

	carl_ctrl_model i_model (.pclk(pclk), .parallel_select(parallel_select),
		.serial_shift_feed(serial_shift_feed), .stage1_load_strobe(stage1_load_strobe),
		.stage1_clock(stage1_clock), .in_word(in_word), .sel(sel),
		.stage2_clock(stage2_clock), .stage2_load_strobe(stage2_load_strobe),
		.stage3_clock(stage3_clock));

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task check_word(input logic [31:0] got, input logic [31:0] ex, input string what);
		samples_checked++;
		if (got !== ex) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, ex);
		end
	endtask : check_word

	task check_bit(input logic got, input logic ex, input string what);
		check_word({31'h0, got}, {31'h0, ex}, what);
	endtask : check_bit

	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask : settle

	// ----------------------------------------
	// APB access, read data checked unless writing
	// ----------------------------------------
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ex, input logic ee);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// A slave that never answers counts here, not only at the global timeout
		check_bit(pready, 1'b1, "pready");
		if (!w)
			check_word(prdata, ex, "rdata");
		check_bit(pslverr, ee, "pslverr");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc

	// One coordinate through stages one and two, expectation built here
	task run_line(input logic [11:0] w, input carl_sel_t s, input logic am, input logic ser);
		logic [11:0] pv;
		logic [11:0] op;
		logic [12:0] t;
		logic        sg;
		logic        ov;
		logic [11:0] loc;
		logic [11:0] dsp;
		pv = s.savepoint_pick ? aux_e : (s.parity_choice ? even_e : odd_e);
		op = s.subtract_select ? ~pv : pv;
		t = {1'b0, w} + {1'b0, op} + {12'h000, s.subtract_select};
		sg = w[11] ^ op[11] ^ t[12];
		ov = sg ^ t[11];
		loc = am ? w : t[11:0];
		dsp = am ? t[11:0] : w;
		if (ser)
			i_model.shift_in(w);
		else
			i_model.stage1(w, 1'b1, 1'b1);
		acc(1'b0, CARL_OFF_HELD, 32'h0, {20'h0, w}, 1'b0);
		check_bit(serial_shift_exit, w[11], "exit");
		i_model.stage2(s, 1'b1);
		if (next_even)
			even_e = loc;
		else
			odd_e = loc;
		next_even = ~next_even;
		acc(1'b0, CARL_OFF_TRUE, 32'h0, {4'h0, even_e, 4'h0, odd_e}, 1'b0);
		acc(1'b0, CARL_OFF_RESULT, 32'h0, {16'h0, next_even, t[12], ov, sg, dsp}, 1'b0);
		check_word({20'h0, displacement_q}, {20'h0, dsp}, "disp");
		check_word({29'h0, flags_q}, {29'h0, sg, ov, t[12]}, "flags");
		check_word({8'h0, true_even_q, true_odd_q}, {8'h0, even_e, odd_e}, "true");
	endtask : run_line

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{odd_e, even_e, aux_e, next_even} = 37'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			acc(1'b0, 8'(i * 4), 32'h0, 32'h0, 1'b0);
		acc(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		acc(1'b1, 8'h24, 32'hFFFF_FFFF, 32'h0, 1'b1);
		acc(1'b1, CARL_OFF_HELD, 32'h0000_0FFF, 32'h0, 1'b0);
		acc(1'b0, CARL_OFF_HELD, 32'h0, 32'h0, 1'b0);
		acc(1'b1, CARL_OFF_AUX, 32'h0000_05A5, 32'h0, 1'b0);
		aux_e = 12'h5A5;
		acc(1'b0, CARL_OFF_AUX, 32'h0, 32'h0000_05A5, 1'b0);
		$display("test registers done");
		run_line(12'h123, 3'h2, 1'b0, 1'b0);
		run_line(12'h700, 3'h0, 1'b0, 1'b0);
		acc(1'b1, CARL_OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
		run_line(12'h100, 3'h6, 1'b1, 1'b0);
		run_line(12'h200, 3'h4, 1'b1, 1'b0);
		acc(1'b1, CARL_OFF_CTRL, 32'h0, 32'h0, 1'b0);
		run_line(12'hA5C, 3'h1, 1'b0, 1'b1);
		i_model.stage1(12'hFFF, 1'b1, 1'b0);
		i_model.stage1(12'hFFF, 1'b0, 1'b1);
		// Clock enable low must swallow a full capture request
		ce <= 1'b0;
		i_model.stage1(12'hFFF, 1'b1, 1'b1);
		ce <= 1'b1;
		acc(1'b0, CARL_OFF_HELD, 32'h0, 32'h0000_0A5C, 1'b0);
		$display("test datapath done");
		for (int k = 0; k < 3; k++) begin
			i_model.set_sel({1'b1, k == 1, k == 2});
			settle();
			check_word({20'h0, prev_value_bus},
				{20'h0, k == 2 ? aux_e : (k == 1 ? even_e : odd_e)}, "bus");
		end
		$display("test bus done");
		acc(1'b0, CARL_OFF_IRQ_ST, 32'h0, 32'h0000_0003, 1'b0);
		check_bit(irq, 1'b0, "irq off");
		acc(1'b1, CARL_OFF_IRQ_EN, 32'h0000_0001, 32'h0, 1'b0);
		settle();
		check_bit(irq, 1'b1, "irq on");
		acc(1'b1, CARL_OFF_IRQ_EN, 32'h0000_0004, 32'h0, 1'b0);
		settle();
		check_bit(irq, 1'b0, "irq masked");
		i_model.stage3();
		settle();
		check_word({8'h0, stage3_even_q, stage3_odd_q}, {8'h0, even_e, odd_e}, "st3");
		check_bit(irq, 1'b1, "irq st3");
		acc(1'b1, CARL_OFF_IRQ_CLR, 32'h0000_0007, 32'h0, 1'b0);
		acc(1'b0, CARL_OFF_IRQ_ST, 32'h0, 32'h0, 1'b0);
		settle();
		check_bit(irq, 1'b0, "irq cleared");
		$display("test interrupt done");
		summarize();
	end
endmodule : testbench

// ---- rtl/carl_adder.sv ----
`timescale 1ns/100ps
// Functional notes
// RULE1: Three buffering stages, each advanced by its own stage clock.
// RULE2: Parallel-select low makes the input register shift serially instead.
// RULE3: Parallel word is twelve bits, first bit most significant.
// RULE4: Input register captures only when stage-one strobe and clock are high.
// RULE5: Input register output feeds adder with previous-value word as other operand.
// RULE6: Relative input: location is input plus current point, displacement is input.
// RULE7: Absolute input: location is input, displacement is input minus current point.
// RULE8: Current point comes from whichever true register holds the endpoint.
// RULE9: Three selects choose odd, even or auxiliary and whether to complement.
// RULE10: Auxiliary inputs route other register values onto the previous-value bus.
// RULE11: Previous-value bus is driven out for returning saved points to memory.
// RULE12: Subtraction feeds the previous-value operand inverted, one's complement.
// RULE13: Subtract-select also forces adder carry-in high.
// RULE14: Adder yields one carry-out for the upper extension slice.
// RULE15: Sign is an extra full-adder bit over sign-extended operands.
// RULE16: Overflow when sign differs from the twelfth sum bit.
// RULE17: Slice holds only low twelve bits; upper bits chain through carry.
// RULE18: Odd and even true registers load alternately at each stage-two clock; the code loads only while stage2_load_strobe is also high.
// RULE19: Subtract complements with carry; parity high picks even; savepoint picks aux.
module carl_adder #(
	parameter int W = carl_pkg::CARL_WORD_W
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic                      irq,
	input  wire logic                 parallel_select,
	input  wire logic                 serial_shift_feed,
	output logic                      serial_shift_exit,
	input  wire logic                 stage1_load_strobe,
	input  wire logic                 stage1_clock,
	input  wire logic [W-1:0]         in_word,
	input  wire carl_pkg::carl_sel_t  sel,
	input  wire logic                 stage2_clock,
	input  wire logic                 stage2_load_strobe,
	input  wire logic                 stage3_clock,
	output logic      [W-1:0]         prev_value_bus,
	output logic      [W-1:0]         true_odd_q,
	output logic      [W-1:0]         true_even_q,
	output logic      [W-1:0]         displacement_q,
	output carl_pkg::carl_flags_t     flags_q,
	output logic      [W-1:0]         stage3_odd_q,
	output logic      [W-1:0]         stage3_even_q
);
	import carl_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [W-1:0]            held_input_word_reg;
	logic [W-1:0]            true_odd_reg;
	logic [W-1:0]            true_even_reg;
	logic                    load_even_reg;
	logic                    abs_input_reg;
	logic [W-1:0]            aux_reg_inputs;
	logic [CARL_EVT_W-1:0]   evt_stat_reg;
	logic [CARL_EVT_W-1:0]   evt_en_reg;
	logic [CARL_EVT_W-1:0]   evt_set;
	logic [CARL_EVT_W-1:0]   evt_clr;
	carl_apb_state_t         apb_state_reg;
	logic [W-1:0]            prev_word;
	logic [W-1:0]            old_operand;
	logic [W:0]              sum_full;
	logic [W-1:0]            sum_word;
	logic                    carry_top;
	logic                    sign_bit;
	logic                    overflow_bit;
	logic [W-1:0]            abs_location;
	logic [W-1:0]            rel_displacement;
	logic                    s1_parallel;
	logic                    s1_serial;
	logic                    s2_load;
	logic                    s3_load;
	logic                    wr_fire;
	logic                    rd_fire;
	logic [31:0]             rd_data;
	logic                    rd_hit;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	// ----------------------------------------
	// Stage one: input register
	// ----------------------------------------
	assign s1_parallel = ce && parallel_select && stage1_load_strobe && stage1_clock;
	assign s1_serial   = ce && !parallel_select && stage1_clock;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_input_word_reg <= CARL_WORD_RST;
		end else if (s1_parallel) begin
			held_input_word_reg <= in_word; // [RULE3] [RULE4]
		end else if (s1_serial) begin
			// Most significant bit leaves first, feed enters at the bottom
			held_input_word_reg <= {held_input_word_reg[W-2:0], serial_shift_feed}; // [RULE2]
		end
	end

	assign serial_shift_exit = held_input_word_reg[W-1];

	// ----------------------------------------
	// Operand select and adder
	// ----------------------------------------
	always_comb begin
		if (sel.savepoint_pick) begin
			prev_word = aux_reg_inputs; // [RULE10] [RULE19]
		end else if (sel.parity_choice) begin
			prev_word = true_even_reg; // [RULE8] [RULE19]
		end else begin
			prev_word = true_odd_reg; // [RULE8] [RULE9]
		end
	end

	// One's complement plus carry-in gives a two's complement subtract
	assign old_operand = sel.subtract_select ? ~prev_word : prev_word; // [RULE12]
	assign sum_full    = {1'b0, held_input_word_reg} + {1'b0, old_operand}
		+ {{W{1'b0}}, sel.subtract_select}; // [RULE5] [RULE13]
	assign sum_word    = sum_full[W-1:0];
	assign carry_top   = sum_full[W]; // [RULE14] [RULE17]
	// Extra full-adder bit on sign-extended operands, absorbs adder overflow
	assign sign_bit    = held_input_word_reg[W-1] ^ old_operand[W-1] ^ carry_top; // [RULE15]
	assign overflow_bit = sign_bit ^ sum_word[W-1]; // [RULE16]

	always_comb begin
		if (abs_input_reg) begin
			abs_location     = held_input_word_reg; // [RULE7]
			rel_displacement = sum_word;
		end else begin
			abs_location     = sum_word; // [RULE6]
			rel_displacement = held_input_word_reg;
		end
	end

	// ----------------------------------------
	// Stage two: true registers, alternating
	// ----------------------------------------
	assign s2_load = ce && stage2_clock && stage2_load_strobe;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			true_odd_reg  <= CARL_WORD_RST;
			true_even_reg <= CARL_WORD_RST;
			load_even_reg <= 1'b0;
		end else if (s2_load) begin
			if (load_even_reg) begin
				true_even_reg <= abs_location; // [RULE18] [RULE1]
			end else begin
				true_odd_reg <= abs_location; // [RULE18]
			end
			load_even_reg <= !load_even_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			displacement_q <= CARL_WORD_RST;
			flags_q        <= '0;
		end else if (s2_load) begin
			displacement_q    <= rel_displacement;
			flags_q.sign      <= sign_bit; // [RULE15]
			flags_q.overflow  <= overflow_bit; // [RULE16]
			flags_q.carry_out <= carry_top; // [RULE14]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			true_odd_q  <= CARL_WORD_RST;
			true_even_q <= CARL_WORD_RST;
			prev_value_bus <= CARL_WORD_RST;
		end else if (ce) begin
			true_odd_q     <= true_odd_reg;
			true_even_q    <= true_even_reg;
			prev_value_bus <= prev_word; // [RULE11]
		end
	end

	// ----------------------------------------
	// Stage three: output buffer
	// ----------------------------------------
	assign s3_load = ce && stage3_clock;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage3_odd_q  <= CARL_WORD_RST;
			stage3_even_q <= CARL_WORD_RST;
		end else if (s3_load) begin
			stage3_odd_q  <= true_odd_reg; // [RULE1]
			stage3_even_q <= true_even_reg;
		end
	end

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	// Registered answer keeps every port on a flop at the cost of a cycle
	assign wr_fire = ce && psel && penable && pwrite && (apb_state_reg == CARL_APB_WAIT);
	assign rd_fire = ce && psel && penable && !pwrite && (apb_state_reg == CARL_APB_WAIT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state_reg <= CARL_APB_IDLE;
		end else if (ce) begin
			case (apb_state_reg)
				CARL_APB_IDLE: begin
					if (psel && !penable) begin
						apb_state_reg <= CARL_APB_WAIT;
					end
				end
				CARL_APB_WAIT: begin
					if (psel && penable) begin
						apb_state_reg <= CARL_APB_DONE;
					end
				end
				CARL_APB_DONE: begin
					apb_state_reg <= (psel && !penable) ? CARL_APB_WAIT : CARL_APB_IDLE;
				end
				default: begin
					apb_state_reg <= CARL_APB_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		if (reg_hit(paddr, CARL_OFF_CTRL)) begin
			rd_data[CARL_CTRL_ABS_BIT] = abs_input_reg;
		end else if (reg_hit(paddr, CARL_OFF_AUX)) begin
			rd_data[W-1:0] = aux_reg_inputs;
		end else if (reg_hit(paddr, CARL_OFF_HELD)) begin
			rd_data[W-1:0] = held_input_word_reg;
		end else if (reg_hit(paddr, CARL_OFF_TRUE)) begin
			rd_data[W-1:0] = true_odd_reg;
			rd_data[CARL_TRUE_EVEN_LSB +: W] = true_even_reg;
		end else if (reg_hit(paddr, CARL_OFF_RESULT)) begin
			rd_data[W-1:0]                 = displacement_q;
			rd_data[CARL_RES_SIGN_BIT]     = flags_q.sign;
			rd_data[CARL_RES_OVF_BIT]      = flags_q.overflow;
			rd_data[CARL_RES_CARRY_BIT]    = flags_q.carry_out;
			rd_data[CARL_RES_PARITY_BIT]   = load_even_reg;
		end else if (reg_hit(paddr, CARL_OFF_IRQ_ST)) begin
			rd_data[CARL_EVT_W-1:0] = evt_stat_reg;
		end else if (reg_hit(paddr, CARL_OFF_IRQ_EN)) begin
			rd_data[CARL_EVT_W-1:0] = evt_en_reg;
		end else if (reg_hit(paddr, CARL_OFF_IRQ_CLR)) begin
			rd_data = 32'h0000_0000;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= wr_fire || rd_fire;
			pslverr <= (wr_fire || rd_fire) && !rd_hit;
			prdata  <= (rd_fire && rd_hit) ? rd_data : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abs_input_reg  <= 1'b0;
			aux_reg_inputs <= CARL_WORD_RST;
			evt_en_reg     <= CARL_EVT_RST;
		end else if (wr_fire) begin
			if (reg_hit(paddr, CARL_OFF_CTRL)) begin
				abs_input_reg <= pwdata[CARL_CTRL_ABS_BIT];
			end
			if (reg_hit(paddr, CARL_OFF_AUX)) begin
				aux_reg_inputs <= pwdata[W-1:0]; // [RULE10]
			end
			if (reg_hit(paddr, CARL_OFF_IRQ_EN)) begin
				evt_en_reg <= pwdata[CARL_EVT_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupt status, set beats clear
	// ----------------------------------------
	assign evt_set[CARL_EVT_LOAD2] = s2_load;
	assign evt_set[CARL_EVT_OVF]   = s2_load && overflow_bit;
	assign evt_set[CARL_EVT_LOAD3] = s3_load;
	assign evt_clr = (wr_fire && reg_hit(paddr, CARL_OFF_IRQ_CLR)) ?
		pwdata[CARL_EVT_W-1:0] : CARL_EVT_RST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_stat_reg <= CARL_EVT_RST;
			irq          <= 1'b0;
		end else if (ce) begin
			evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
			irq          <= |(((evt_stat_reg & ~evt_clr) | evt_set) & evt_en_reg);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_par_take;
		ce && parallel_select && stage1_load_strobe && stage1_clock;
	endsequence

	sequence s_load_then_flip;
		s2_load ##1 (load_even_reg != $past(load_even_reg));
	endsequence

	chk_parallel_capture: assert property ( // [RULE4]
		s_par_take |=> held_input_word_reg == $past(in_word))
		else $error("parallel word not captured");

	chk_serial_shift_in: assert property ( // [RULE2]
		s1_serial |=> held_input_word_reg ==
			{$past(held_input_word_reg[W-2:0]), $past(serial_shift_feed)})
		else $error("serial shift wrong");

	chk_input_hold: assert property ( // [RULE4]
		(ce && !stage1_clock) |=> $stable(held_input_word_reg))
		else $error("input register moved without stage clock");

	chk_sub_twos: assert property ( // [RULE13]
		sel.subtract_select |-> sum_word ==
			W'(held_input_word_reg - prev_word))
		else $error("subtract result wrong");

	chk_add_plain: assert property ( // [RULE12]
		!sel.subtract_select |-> sum_word ==
			W'(held_input_word_reg + prev_word))
		else $error("add result wrong");

	chk_sign_ext: assert property ( // [RULE15]
		sign_bit == ((W+1)'({held_input_word_reg[W-1], held_input_word_reg}
			+ {old_operand[W-1], old_operand}
			+ {{W{1'b0}}, sel.subtract_select}) >> W))
		else $error("sign bit wrong");

	chk_overflow_flag: assert property ( // [RULE16]
		s2_load |=> flags_q.overflow == ($past(sign_bit) != $past(sum_word[W-1])))
		else $error("overflow flag wrong");

	chk_alternate_load: assert property ( // [RULE18]
		s2_load |-> s_load_then_flip)
		else $error("true registers not alternating");

	chk_abs_location: assert property ( // [RULE7]
		(s2_load && abs_input_reg && load_even_reg) |=>
			true_even_reg == $past(held_input_word_reg))
		else $error("absolute location wrong");

	chk_rel_location: assert property ( // [RULE6]
		(s2_load && !abs_input_reg && !load_even_reg) |=>
			true_odd_reg == $past(sum_word) && displacement_q == $past(held_input_word_reg))
		else $error("relative location wrong");

	chk_prev_bus_out: assert property ( // [RULE11]
		(ce && !sel.savepoint_pick && sel.parity_choice) |=>
			prev_value_bus == $past(true_even_reg))
		else $error("previous-value bus wrong");

	chk_stage3_copy: assert property ( // [RULE1]
		s3_load |=> stage3_odd_q == $past(true_odd_reg) ##1 1'b1)
		else $error("stage three not loaded");

endmodule : carl_adder

// ---- rtl/carl_pkg.sv ----
package carl_pkg;

	// ----------------------------------------
	// Datapath sizing and reset values
	// ----------------------------------------
	localparam int          CARL_WORD_W  = 12;
	localparam logic [11:0] CARL_WORD_RST = 12'h000;

	// ----------------------------------------
	// APB register byte offsets
	// ----------------------------------------
	localparam logic [7:0]  CARL_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  CARL_OFF_AUX     = 8'h04;
	localparam logic [7:0]  CARL_OFF_HELD    = 8'h08;
	localparam logic [7:0]  CARL_OFF_TRUE    = 8'h0C;
	localparam logic [7:0]  CARL_OFF_RESULT  = 8'h10;
	localparam logic [7:0]  CARL_OFF_IRQ_ST  = 8'h14;
	localparam logic [7:0]  CARL_OFF_IRQ_EN  = 8'h18;
	localparam logic [7:0]  CARL_OFF_IRQ_CLR = 8'h1C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          CARL_CTRL_ABS_BIT   = 0;
	localparam int          CARL_TRUE_EVEN_LSB  = 16;
	localparam int          CARL_RES_SIGN_BIT   = 12;
	localparam int          CARL_RES_OVF_BIT    = 13;
	localparam int          CARL_RES_CARRY_BIT  = 14;
	localparam int          CARL_RES_PARITY_BIT = 15;
	localparam int          CARL_EVT_W          = 3;
	localparam int          CARL_EVT_LOAD2      = 0;
	localparam int          CARL_EVT_OVF        = 1;
	localparam int          CARL_EVT_LOAD3      = 2;
	localparam logic [2:0]  CARL_EVT_RST        = 3'h0;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic subtract_select;
		logic parity_choice;
		logic savepoint_pick;
	} carl_sel_t;

	typedef struct packed {
		logic sign;
		logic overflow;
		logic carry_out;
	} carl_flags_t;

	typedef enum logic [1:0] {
		CARL_APB_IDLE = 2'b00,
		CARL_APB_WAIT = 2'b01,
		CARL_APB_DONE = 2'b10
	} carl_apb_state_t;

endpackage : carl_pkg
